// [common/sec_pkg.sv]
/*
  Shared constants and types for the serial configuration memory controller:
  host command codes, serial opcodes, frame lengths, timing counts, the
  request word that crosses into the link domain and the controller states.
  Assumes a 20 MHz system clock and a separate free-running link clock.
*/
`default_nettype none

package sec_pkg;

  // ==========================================================================
  // Host command codes (prom_opcode_field)
  localparam logic [2:0] SEC_CMD_READ = 3'h0;
  localparam logic [2:0] SEC_CMD_LOCK_MODIFY = 3'h1;
  localparam logic [2:0] SEC_CMD_UNLOCK_MODIFY = 3'h2;
  localparam logic [2:0] SEC_CMD_WRITE = 3'h3;
  localparam logic [2:0] SEC_CMD_WRITE_EVERY_LOCATION = 3'h4;
  localparam logic [2:0] SEC_CMD_ERASE = 3'h5;
  localparam logic [2:0] SEC_CMD_ERASE_EVERY_LOCATION = 3'h6;
  localparam logic [2:0] SEC_CMD_RELOAD = 3'h7;

  // ==========================================================================
  // Serial opcodes and the sub-codes carried in the top two address bits
  localparam logic [1:0] SEC_OP_MISC = 2'h0;
  localparam logic [1:0] SEC_OP_WRITE = 2'h1;
  localparam logic [1:0] SEC_OP_READ = 2'h2;
  localparam logic [1:0] SEC_OP_ERASE = 2'h3;
  localparam logic [1:0] SEC_SUB_LOCK_MODIFY = 2'h0;
  localparam logic [1:0] SEC_SUB_WRITE_EVERY_LOCATION = 2'h1;
  localparam logic [1:0] SEC_SUB_ERASE_EVERY_LOCATION = 2'h2;
  localparam logic [1:0] SEC_SUB_UNLOCK_MODIFY = 2'h3;

  // ==========================================================================
  // Address auto-load
  localparam logic [7:0] SEC_SIGNATURE = 8'hA5;
  localparam logic [6:0] SEC_SIG_LOC = 7'h00;
  localparam logic [2:0] SEC_ADDR_BYTES = 3'h6;

  // ==========================================================================
  // Frame shape: start bit, opcode and location form the header
  localparam logic [4:0] SEC_HDR_BITS = 5'h0A;
  localparam logic [4:0] SEC_FRAME_LEN = 5'h12;
  localparam logic [2:0] SEC_BIT_LAST = 3'h7;

  // ==========================================================================
  // Timing
  localparam int unsigned SEC_SYS_CLK_HZ = 20000000;
  localparam int unsigned SEC_TMO_MS = 30;
  localparam int unsigned SEC_TMO_CYC = SEC_TMO_MS * (SEC_SYS_CLK_HZ / 1000);
  typedef logic [19:0] sec_tmo_t;

  // ==========================================================================
  // Request word handed to the link domain
  typedef struct packed {
    logic [17:0] frame;
    logic long_frame;
    logic poll;
    logic rd;
  } sec_req_t;

  // System side sequencer, Gray along idle, wait, evaluate
  typedef enum logic [1:0] {
    SEC_S_IDLE = 2'h0,
    SEC_S_WAIT = 2'h1,
    SEC_S_EVAL = 2'h3
  } sec_state_t;

  // Link side engine, Gray along idle, shift, gap, poll
  typedef enum logic [1:0] {
    SEC_L_IDLE = 2'h0,
    SEC_L_SHIFT = 2'h1,
    SEC_L_GAP = 2'h3,
    SEC_L_POLL = 2'h2
  } sec_lstate_t;

endpackage : sec_pkg

`default_nettype wire

// [logic/sec_sync.sv]
/*
  Two flip-flop level synchroniser, any width.
  Assumes each bit is an independent level, or a word held stable by a
  handshake while it is sampled.
*/
`default_nettype none

module sec_sync #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk,
  // Levels in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    meta_r <= d;
    q <= meta_r;
  end

endmodule : sec_sync

`default_nettype wire

// [logic/sec_top.sv]
/*
  Serial configuration memory controller: signature check and station
  address auto-load, host commands with busy handshake, timeout, and the
  three-wire serial engine on its own link clock.
  Assumes host strobes are synchronous to sys_clk and the memory pins and
  monitor inputs are asynchronous.
*/
`default_nettype none

module sec_top
  import sec_pkg::*;
#(
  parameter int unsigned TMO_CYC = SEC_TMO_CYC
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  // Link clock
  input wire logic link_clk,
  // Command register write
  input wire logic cmd_go,
  input wire logic [2:0] prom_opcode_field,
  input wire logic [6:0] prom_location_field,
  // Data register write
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  // Status and readback
  output logic prom_busy_bit,
  output logic prom_timeout_bit,
  output logic addr_loaded_bit,
  output logic reload_success_bit,
  output logic [7:0] prom_data_register,
  output logic [31:0] station_address_low,
  output logic [15:0] station_address_high,
  // Pin function selection
  input wire logic prom_if_enable,
  input wire logic gp_mon_sel,
  input wire logic gp_data_val,
  input wire logic gp_clk_val,
  input wire logic mii_mon_data,
  input wire logic mii_mon_clk,
  // Memory pins
  output logic prom_chip_select,
  output logic prom_serial_clock_pin,
  output logic prom_serial_data_pin_o,
  output logic prom_serial_data_pin_oe,
  input wire logic prom_serial_data_pin_i
);

  // ==========================================================================
  // Declarations
  sec_state_t st_r;
  sec_lstate_t lst_r;
  sec_req_t req_r, next_req;
  logic busy_r, tmo_r, loaded_r, rel_ok_r, load_pend_r, ld_r, rel_r, abort_r;
  logic req_tgl_r, done_seen_r, done_s;
  logic [2:0] idx_r, cmd_r;
  logic [7:0] data_r;
  logic [47:0] addr_r;
  sec_tmo_t cnt_r;
  logic [9:0] lsync;
  logic lrst_n, req_s, abort_s, en_s, mon_s, gpd_s, gpc_s, mond_s, monc_s, din_s;
  logic req_seen_r, done_tgl_r, poll_r, rd_r;
  logic [2:0] ph_r;
  logic [4:0] bit_r, len_r, skc_r;
  logic [17:0] sh_r;
  logic [7:0] rdata_r;
  logic cs_r, sk_r, do_r, oe_r, sk_d_r;

  // ==========================================================================
  // Crossings
  sec_sync #(.W(1)) u_sync_sys (
    .clk(sys_clk),
    .d(done_tgl_r),
    .q(done_s)
  );

  sec_sync #(.W(10)) u_sync_link (
    .clk(link_clk),
    .d({rst_n, req_tgl_r, abort_r, prom_if_enable, gp_mon_sel, gp_data_val,
        gp_clk_val, mii_mon_data, mii_mon_clk, prom_serial_data_pin_i}),
    .q(lsync)
  );

  assign {lrst_n, req_s, abort_s, en_s, mon_s, gpd_s, gpc_s, mond_s, monc_s, din_s} = lsync;

  // ==========================================================================
  // Frame builder: header is start bit, opcode, 7-bit location
  function automatic sec_req_t mk_req(input logic [2:0] cmd, input logic [6:0] loc,
                                      input logic [7:0] dat);
    sec_req_t r;
    r = '{{1'h1, SEC_OP_READ, loc, 8'h00}, 1'h1, 1'h0, 1'h1};
    case (cmd)
      SEC_CMD_LOCK_MODIFY: r = '{{1'h1, SEC_OP_MISC, SEC_SUB_LOCK_MODIFY, 5'h00, 8'h00}, 1'h0, 1'h0, 1'h0};
      SEC_CMD_UNLOCK_MODIFY: r = '{{1'h1, SEC_OP_MISC, SEC_SUB_UNLOCK_MODIFY, 5'h00, 8'h00}, 1'h0, 1'h0, 1'h0};
      SEC_CMD_WRITE: r = '{{1'h1, SEC_OP_WRITE, loc, dat}, 1'h1, 1'h1, 1'h0};
      SEC_CMD_WRITE_EVERY_LOCATION: r = '{{1'h1, SEC_OP_MISC, SEC_SUB_WRITE_EVERY_LOCATION, 5'h00, dat}, 1'h1, 1'h1, 1'h0};
      SEC_CMD_ERASE: r = '{{1'h1, SEC_OP_ERASE, loc, 8'h00}, 1'h0, 1'h1, 1'h0};
      SEC_CMD_ERASE_EVERY_LOCATION: r = '{{1'h1, SEC_OP_MISC, SEC_SUB_ERASE_EVERY_LOCATION, 5'h00, 8'h00}, 1'h0, 1'h1, 1'h0};
      default: ;
    endcase
    return r;
  endfunction : mk_req

  // ==========================================================================
  // System side decode
  wire done_evt = done_s ^ done_seen_r;
  wire host_go = cmd_go && !busy_r;
  wire host_rel = host_go && (prom_opcode_field == SEC_CMD_RELOAD);
  wire start_load = load_pend_r || host_rel;
  wire sig_ok = rdata_r == SEC_SIGNATURE;
  wire eval_ok = (st_r == SEC_S_EVAL) && !abort_r;
  wire load_more = eval_ok && ld_r && ((idx_r == 3'h0) ? sig_ok : (idx_r != SEC_ADDR_BYTES));
  wire issue = ((st_r == SEC_S_IDLE) && (start_load || host_go)) || load_more;
  wire [6:0] load_loc = (st_r == SEC_S_IDLE) ? SEC_SIG_LOC : {4'h0, idx_r + 3'h1};
  wire [5:0] byte_lsb = {idx_r - 3'h1, 3'h0};
  wire tmo_hit = cnt_r == sec_tmo_t'(TMO_CYC - 1);
  wire load_done = eval_ok && ld_r && (idx_r == SEC_ADDR_BYTES);

  assign next_req = ((st_r == SEC_S_IDLE) && !start_load)
                  ? mk_req(prom_opcode_field, prom_location_field, data_r)
                  : mk_req(SEC_CMD_READ, load_loc, 8'h00);

  // Sequencer state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= SEC_S_IDLE;
      done_seen_r <= 1'h0;
    end else begin
      done_seen_r <= done_s;
      unique case (st_r)
        SEC_S_IDLE: st_r <= issue ? SEC_S_WAIT : SEC_S_IDLE;
        SEC_S_WAIT: st_r <= done_evt ? SEC_S_EVAL : SEC_S_WAIT;
        SEC_S_EVAL: st_r <= issue ? SEC_S_WAIT : SEC_S_IDLE;
        default: st_r <= SEC_S_IDLE;
      endcase
    end
  end

  // Request word and toggle; the word stays put until the next toggle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_r <= '0;
      req_tgl_r <= 1'h0;
    end else if (issue) begin
      req_r <= next_req;
      req_tgl_r <= ~req_tgl_r;
    end
  end

  // Response watchdog, raises abort to the link engine
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      abort_r <= 1'h0;
    end else if (issue) begin
      cnt_r <= '0;
      abort_r <= 1'h0;
    end else if ((st_r == SEC_S_WAIT) && !abort_r) begin
      cnt_r <= cnt_r + sec_tmo_t'(1);
      abort_r <= tmo_hit;
    end
  end

  // Pending auto-load after reset or soft reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      load_pend_r <= 1'h1;
    end else if (soft_reset) begin
      load_pend_r <= 1'h1;
    end else if (st_r == SEC_S_IDLE) begin
      load_pend_r <= 1'h0;
    end
  end

  // Busy, status bits and load progress
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_r <= 1'h0;
      tmo_r <= 1'h0;
      loaded_r <= 1'h0;
      rel_ok_r <= 1'h0;
      ld_r <= 1'h0;
      rel_r <= 1'h0;
      idx_r <= 3'h0;
      cmd_r <= SEC_CMD_READ;
    end else if ((st_r == SEC_S_IDLE) && issue) begin
      busy_r <= 1'h1;
      tmo_r <= 1'h0;
      ld_r <= start_load;
      rel_r <= !load_pend_r && host_rel;
      idx_r <= 3'h0;
      cmd_r <= prom_opcode_field;
      if (start_load) begin
        loaded_r <= 1'h0;
        rel_ok_r <= 1'h0;
      end
    end else if (st_r == SEC_S_EVAL) begin
      if (abort_r) begin
        tmo_r <= 1'h1;
      end
      if (load_more) begin
        idx_r <= idx_r + 3'h1;
      end else begin
        busy_r <= 1'h0;
        ld_r <= 1'h0;
      end
      if (load_done) begin
        loaded_r <= 1'h1;
        rel_ok_r <= rel_r;
      end
    end
  end

  // Data and address registers: host writes and read results, loaded address bytes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_r <= 8'h00;
      addr_r <= 48'h0;
    end else if (eval_ok && ld_r && (idx_r != 3'h0)) begin
      addr_r[byte_lsb +: 8] <= rdata_r;
    end else if (eval_ok && !ld_r && (cmd_r == SEC_CMD_READ)) begin
      data_r <= rdata_r;
    end else if (data_wr && !busy_r) begin
      data_r <= data_wdata;
    end
  end

  assign prom_busy_bit = busy_r;
  assign prom_timeout_bit = tmo_r;
  assign addr_loaded_bit = loaded_r;
  assign reload_success_bit = rel_ok_r;
  assign prom_data_register = data_r;
  assign station_address_low = addr_r[31:0];
  assign station_address_high = addr_r[47:32];

  // ==========================================================================
  // Link side engine: each serial bit spans eight link cycles
  wire req_new = req_s ^ req_seen_r;
  wire in_shift = lst_r == SEC_L_SHIFT;
  wire last_bit = bit_r == (len_r - 5'h01);
  wire data_phase = bit_r >= SEC_HDR_BITS;

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      lst_r <= SEC_L_IDLE;
      ph_r <= 3'h0;
      bit_r <= 5'h00;
      len_r <= 5'h00;
      sh_r <= 18'h0;
      poll_r <= 1'h0;
      rd_r <= 1'h0;
      rdata_r <= 8'h00;
      done_tgl_r <= 1'h0;
      req_seen_r <= 1'h0;
    end else begin
      ph_r <= (lst_r == SEC_L_IDLE) ? 3'h0 : ph_r + 3'h1;
      unique case (lst_r)
        SEC_L_IDLE: begin
          req_seen_r <= req_s;
          if (req_new && en_s) begin
            lst_r <= SEC_L_SHIFT;
            bit_r <= 5'h00;
            sh_r <= req_r.frame;
            len_r <= req_r.long_frame ? SEC_FRAME_LEN : SEC_HDR_BITS;
            poll_r <= req_r.poll;
            rd_r <= req_r.rd;
          end else if (req_new) begin
            done_tgl_r <= ~done_tgl_r;
          end
        end
        SEC_L_SHIFT: begin
          if (ph_r == SEC_BIT_LAST) begin
            if (rd_r && data_phase) begin
              rdata_r <= {rdata_r[6:0], din_s};
            end
            sh_r <= {sh_r[16:0], 1'h0};
            bit_r <= bit_r + 5'h01;
            if (last_bit && poll_r) begin
              lst_r <= SEC_L_GAP;
            end else if (last_bit) begin
              lst_r <= SEC_L_IDLE;
              done_tgl_r <= ~done_tgl_r;
            end
          end
        end
        SEC_L_GAP: begin
          if (ph_r == SEC_BIT_LAST) begin
            lst_r <= SEC_L_POLL;
          end
        end
        SEC_L_POLL: begin
          if ((ph_r == SEC_BIT_LAST) && (din_s || abort_s)) begin
            lst_r <= SEC_L_IDLE;
            done_tgl_r <= ~done_tgl_r;
          end
        end
      endcase
    end
  end

  // Pin drive: engine when enabled, else general outputs or monitor
  wire eng_cs = in_shift || (lst_r == SEC_L_POLL);
  wire eng_sk = in_shift && (ph_r[2] ^ ph_r[1]);
  wire eng_oe = in_shift && (!data_phase || !rd_r);
  wire cs_nxt = en_s && eng_cs;
  wire sk_nxt = en_s ? eng_sk : (mon_s ? monc_s : gpc_s);
  wire do_nxt = en_s ? sh_r[17] : (mon_s ? mond_s : gpd_s);
  wire oe_nxt = en_s ? eng_oe : 1'h1;

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      {cs_r, sk_r, do_r, oe_r, sk_d_r} <= 5'h00;
      skc_r <= 5'h00;
    end else begin
      {cs_r, sk_r, do_r, oe_r, sk_d_r} <= {cs_nxt, sk_nxt, do_nxt, oe_nxt, sk_r};
      skc_r <= (lst_r == SEC_L_IDLE) ? 5'h00 : skc_r + {4'h0, sk_r && !sk_d_r};
    end
  end

  assign prom_chip_select = cs_r;
  assign prom_serial_clock_pin = sk_r;
  assign prom_serial_data_pin_o = do_r;
  assign prom_serial_data_pin_oe = oe_r;

  // ==========================================================================
  // Assertions
  a_first_sig_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_r == SEC_S_IDLE) && start_load |=> req_r.frame[17:8] == {1'h1, SEC_OP_READ, SEC_SIG_LOC}
  ) else $error("auto-load did not start at signature location");

  a_bad_sig_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    eval_ok && ld_r && (idx_r == 3'h0) && !sig_ok
    |=> (st_r == SEC_S_IDLE) && !busy_r && !loaded_r && $stable(addr_r)
  ) else $error("load continued after bad signature");

  a_byte_placed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    eval_ok && ld_r && (idx_r != 3'h0) |=> addr_r[$past(byte_lsb) +: 8] == $past(rdata_r)
  ) else $error("address byte landed in wrong place");

  a_loaded_six: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(loaded_r) |-> ($past(idx_r) == SEC_ADDR_BYTES) && $past(ld_r) && !busy_r
  ) else $error("loaded bit set before six bytes");

  a_reload_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rel_ok_r) |-> $past(rel_r) && loaded_r
  ) else $error("reload success outside host reload");

  a_busy_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(busy_r) |-> $past(st_r) == SEC_S_EVAL && $past(st_r, 2) == SEC_S_WAIT
  ) else $error("busy cleared without completion");

  a_read_result: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(busy_r) && $past(cmd_r == SEC_CMD_READ && !ld_r && !abort_r)
    |-> data_r == $past(rdata_r)
  ) else $error("read result missing from data register");

  a_timeout_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_r == SEC_S_WAIT) && !abort_r && tmo_hit && !done_evt
    |=> (abort_r && (st_r == SEC_S_WAIT)) ##[1:1000] (tmo_r && !busy_r)
  ) else $error("timeout not reported");

  a_clock_count: assert property (@(posedge link_clk) disable iff (!lrst_n)
    in_shift && (ph_r == SEC_BIT_LAST) && last_bit |-> skc_r == len_r
  ) else $error("wrong serial clock count in frame");

  a_start_bit: assert property (@(posedge link_clk) disable iff (!lrst_n)
    $rose(cs_r) && $past(in_shift) |-> do_r && oe_r
  ) else $error("frame did not open with start bit");

  a_poll_listen: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (lst_r == SEC_L_POLL) && en_s |=> cs_r && !oe_r && !sk_r
  ) else $error("data pin driven while polling");

  c_autoload_ok: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(loaded_r) && !rel_r);
  c_reload_ok: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(rel_ok_r));
  c_timeout: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(tmo_r));
  c_read_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(busy_r) && $past(cmd_r == SEC_CMD_READ && !ld_r));

endmodule : sec_top

`default_nettype wire

// [test/sec_prom_model.sv]
/*
  Behavioural three-wire serial memory, 128 locations of 8 bits.
  Assumes the bench resolves the shared data wire and feeds its level to di.
*/
`default_nettype none

module sec_prom_model (
  // Memory pins
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  output logic do_o,
  output logic do_oe,
  // Bench control: never report ready
  input wire logic stuck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:127];
  logic en = 1'b0;
  logic [17:0] sh = 18'h00000;
  logic [7:0] rbuf = 8'h00;
  logic [4:0] n = 5'h00;
  logic rdg = 1'b0;
  logic drv = 1'b0;
  logic pend = 1'b0;
  logic rdy = 1'b1;

  // ==========================================================================
  // Data wire: read bits, then ready status while selected after a modify
  assign do_oe = cs & (drv | pend);
  assign do_o = pend ? rdy : rbuf[7];

  // Program cycle: busy for a while, ready later unless told to hang
  task automatic go_busy();
    pend = 1'b1;
    rdy = 1'b0;
    if (!stuck) rdy <= #2000 1'b1;
  endtask : go_busy

  // Frame boundaries; a select without clocks is a status poll
  always @(posedge cs) n = 5'h00;
  always @(negedge cs) begin
    if (n == 5'h00) pend = 1'b0;
    rdg = 1'b0;
    drv = 1'b0;
  end

  // Shift in on each rising clock, decode header and data, MSB first
  always @(posedge sk) if (cs) begin
    n = n + 5'h01;
    sh = {sh[16:0], di};
    if (rdg && n == 5'h0B) drv = 1'b1;
    if (rdg && n > 5'h0B) rbuf = {rbuf[6:0], 1'b0};
    if (n == 5'h0A && sh[9]) begin
      case (sh[8:7])
        2'h2: begin
          rdg = 1'b1;
          rbuf = mem[sh[6:0]];
        end
        2'h3: begin
          if (en) mem[sh[6:0]] = 8'hFF;
          go_busy();
        end
        2'h0: begin
          if (sh[6:5] == 2'h0) en = 1'b0;
          if (sh[6:5] == 2'h3) en = 1'b1;
          if (sh[6:5] == 2'h2) begin
            if (en) foreach (mem[i]) mem[i] = 8'hFF;
            go_busy();
          end
        end
        default: ;
      endcase
    end
    if (n == 5'h12 && sh[17]) begin
      if (sh[16:15] == 2'h1) begin
        if (en) mem[sh[14:8]] = sh[7:0];
        go_busy();
      end
      if (sh[16:15] == 2'h0 && sh[14:13] == 2'h1) begin
        if (en) foreach (mem[i]) mem[i] = sh[7:0];
        go_busy();
      end
    end
  end
endmodule : sec_prom_model

`default_nettype wire

// [test/testbench.sv]
/*
  Self-checking bench for the serial memory controller.
  Assumes the behavioural memory model and a free 125 ns link clock.
*/
`default_nettype none

module testbench;
  import sec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, soft_reset = 1'b0;
  logic cmd_go = 1'b0, data_wr = 1'b0, stuck = 1'b0, last = 1'b0;
  logic [2:0] opc = 3'h0;
  logic [6:0] loc = 7'h00;
  logic [7:0] wd = 8'h00;
  logic en = 1'b1, msel = 1'b0, gdat = 1'b0, gclk = 1'b0, mdat = 1'b0, mclk = 1'b0;
  logic busy, tmo, loaded, rls, cs, sck, d_o, d_oe, m_o, m_oe, pin;
  logic [7:0] dreg;
  logic [31:0] sal;
  logic [15:0] sah;
  logic [4:0] cnt = 5'h00, ncl = 5'h00;
  int err_total = 0, compares = 0;

  // ==========================================================================
  // Clocks, unrelated in phase
  initial forever #25 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  // Shared data wire; an undriven wire toggles so it never looks valid
  always @(posedge link_clk) last <= pin;
  assign pin = d_oe ? d_o : (m_oe ? m_o : ~last);

  // Serial clock pulses per select
  always @(posedge cs) cnt = 5'h00;
  always @(negedge cs) if (cnt != 5'h00) ncl = cnt;
  always @(posedge sck) if (cs) cnt = cnt + 5'h01;

  sec_top #(.TMO_CYC(1000)) u_sec_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .soft_reset(soft_reset), .link_clk(link_clk),
    .cmd_go(cmd_go), .prom_opcode_field(opc), .prom_location_field(loc),
    .data_wr(data_wr), .data_wdata(wd), .prom_busy_bit(busy), .prom_timeout_bit(tmo),
    .addr_loaded_bit(loaded), .reload_success_bit(rls), .prom_data_register(dreg),
    .station_address_low(sal), .station_address_high(sah), .prom_if_enable(en),
    .gp_mon_sel(msel), .gp_data_val(gdat), .gp_clk_val(gclk), .mii_mon_data(mdat),
    .mii_mon_clk(mclk), .prom_chip_select(cs), .prom_serial_clock_pin(sck),
    .prom_serial_data_pin_o(d_o), .prom_serial_data_pin_oe(d_oe),
    .prom_serial_data_pin_i(pin)
  );

  sec_prom_model u_sec_prom_model (
    .cs(cs), .sk(sck), .di(pin), .do_o(m_o), .do_oe(m_oe), .stuck(stuck)
  );

  // ==========================================================================
  // Compare, verdict, bus tasks
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic wait_idle();
    int k;
    k = 0;
    // Look just after the edge so a busy launched there is already visible
    #1;
    while (busy !== 1'b0 && k < 8000) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (k >= 8000) chk("busy clear", 48'h0, {47'h0, busy});
  endtask : wait_idle

  task automatic op(input logic [2:0] c, input logic [6:0] a);
    @(posedge sys_clk);
    #5;
    cmd_go = 1'b1;
    opc = c;
    loc = a;
    @(posedge sys_clk);
    #5;
    cmd_go = 1'b0;
    wait_idle();
  endtask : op

  task automatic wdat(input logic [7:0] v);
    @(posedge sys_clk);
    #5;
    data_wr = 1'b1;
    wd = v;
    @(posedge sys_clk);
    #5;
    data_wr = 1'b0;
  endtask : wdat

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    op(SEC_CMD_READ, a);
    chk("read data", {40'h0, e}, {40'h0, dreg});
  endtask : rd

  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    foreach (u_sec_prom_model.mem[i]) u_sec_prom_model.mem[i] = 8'(i);
    u_sec_prom_model.mem[0] = 8'hA5;
    for (int i = 1; i < 7; i++) u_sec_prom_model.mem[i] = 8'(8'h11 * i);
    repeat (10) @(posedge sys_clk);
    #5;
    rst_n = 1'b1;
    @(posedge sys_clk);
    wait_idle();
    chk("loaded", 48'h1, {47'h0, loaded});
    chk("reload ok", 48'h0, {47'h0, rls});
    chk("station address", 48'h665544332211, {sah, sal});
    rd(7'h03, 8'h33);
    chk("long clocks", 48'h12, {43'h0, ncl});
    wdat(8'h5A);
    op(SEC_CMD_WRITE, 7'h09);
    rd(7'h09, 8'h09);
    op(SEC_CMD_UNLOCK_MODIFY, 7'h00);
    chk("short clocks", 48'h0A, {43'h0, ncl});
    wdat(8'h5A);
    op(SEC_CMD_WRITE, 7'h7F);
    rd(7'h7F, 8'h5A);
    op(SEC_CMD_ERASE, 7'h7F);
    chk("erase clocks", 48'h0A, {43'h0, ncl});
    rd(7'h7F, 8'hFF);
    wdat(8'h3C);
    op(SEC_CMD_WRITE_EVERY_LOCATION, 7'h00);
    rd(7'h00, 8'h3C);
    rd(7'h64, 8'h3C);
    op(SEC_CMD_ERASE_EVERY_LOCATION, 7'h00);
    rd(7'h40, 8'hFF);
    op(SEC_CMD_LOCK_MODIFY, 7'h00);
    wdat(8'h77);
    op(SEC_CMD_WRITE, 7'h05);
    rd(7'h05, 8'hFF);
    chk("timeout", 48'h0, {47'h0, tmo});
    stuck = 1'b1;
    op(SEC_CMD_UNLOCK_MODIFY, 7'h00);
    op(SEC_CMD_ERASE, 7'h02);
    chk("timeout", 48'h1, {47'h0, tmo});
    stuck = 1'b0;
    op(SEC_CMD_UNLOCK_MODIFY, 7'h00);
    chk("timeout", 48'h0, {47'h0, tmo});
    op(SEC_CMD_RELOAD, 7'h00);
    chk("reload ok", 48'h0, {47'h0, rls});
    chk("loaded", 48'h0, {47'h0, loaded});
    chk("station address", 48'h665544332211, {sah, sal});
    u_sec_prom_model.mem[0] = 8'hA5;
    for (int i = 1; i < 7; i++) u_sec_prom_model.mem[i] = 8'(8'hA0 + i);
    op(SEC_CMD_RELOAD, 7'h00);
    chk("reload ok", 48'h1, {47'h0, rls});
    chk("station address", 48'hA6A5A4A3A2A1, {sah, sal});
    u_sec_prom_model.mem[1] = 8'h0F;
    @(posedge sys_clk);
    #5;
    soft_reset = 1'b1;
    @(posedge sys_clk);
    #5;
    soft_reset = 1'b0;
    repeat (3) @(posedge sys_clk);
    wait_idle();
    chk("reload ok", 48'h0, {47'h0, rls});
    chk("station address", 48'hA6A5A4A3A20F, {sah, sal});
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      #5;
      en = 1'b0;
      msel = k[1];
      gdat = k[0];
      gclk = ~k[0];
      mdat = ~k[0];
      mclk = k[0];
      repeat (16) @(posedge sys_clk);
      chk("data pin", {47'h0, msel ? mdat : gdat}, {47'h0, d_o});
      chk("clock pin", {47'h0, msel ? mclk : gclk}, {47'h0, sck});
      chk("data pin enable", 48'h1, {47'h0, d_oe});
    end
    stop_test();
  end
endmodule : testbench

`default_nettype wire
